// [fifo_cfg_checker.sv]
// Checker: push gating and field views of the FIFO write configuration
`timescale 1ns/1ps
`default_nettype none
module fifo_cfg_checker
(
  // Observed ports
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        flicker_step_en,
  input wire logic        final_after_flicker,
  input wire logic [15:0] light_sample_count,
  input wire logic [15:0] flicker_sample_count,
  input wire logic [1:0]  light_valid,
  input wire logic [1:0]  flicker_valid,
  input wire logic [1:0]  light_push,
  input wire logic [1:0]  flicker_push,
  input wire logic [15:0] flicker_push_data0,
  input wire logic        mod0_light_result_push_en,
  input wire logic [3:0]  mod0_flicker_sample_bits
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic early;
  assign early = light_sample_count < flicker_sample_count;
  AST_WR_EN: assert property (reg_wr && reg_addr == fifo_cfg_pkg::MOD0_CFG_ADDR
    |=> mod0_light_result_push_en == $past(reg_wdata[7])) else $error("enable bit lost");
  AST_GATE_OFF: assert property (light_valid[0] && mod0_light_result_push_en
    && !flicker_step_en |=> light_push[0]) else $error("light dropped, flicker off");
  AST_GATE_DONE: assert property (light_valid[0] && mod0_light_result_push_en
    && !early |=> light_push[0]) else $error("light dropped, flicker done");
  AST_EARLY: assert property (light_valid[0] && flicker_step_en && early
    && !final_after_flicker |=> !light_push[0]) else $error("early light pushed");
  AST_FLK_PUSH: assert property (flicker_valid != 0
    |=> flicker_push == $past(flicker_valid)) else $error("flicker push wrong");
  // Config writes in the sample cycle are excluded: old width applies then
  AST_WIDTH: assert property (flicker_valid[0] && !reg_wr
    |=> (flicker_push_data0 >> (mod0_flicker_sample_bits + 5'd1)) == 0)
    else $error("sample bits above width");
  AST_RSVD: assert property (!reg_rdata[6]) else $error("reserved bit set");
  COV_LIGHT: cover property (light_push[0]);
  COV_FLICK: cover property (flicker_push[0]);
  COV_WRITE: cover property (reg_wr);
endmodule : fifo_cfg_checker
bind fifo_sample_format_cfg fifo_cfg_checker fifo_cfg_checker_inst (.mclk(mclk),
  .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .flicker_step_en(flicker_step_en),
  .final_after_flicker(final_after_flicker), .light_sample_count(light_sample_count),
  .flicker_sample_count(flicker_sample_count), .light_valid(light_valid),
  .flicker_valid(flicker_valid), .light_push(light_push), .flicker_push(flicker_push),
  .flicker_push_data0(flicker_push_data0),
  .mod0_light_result_push_en(mod0_light_result_push_en),
  .mod0_flicker_sample_bits(mod0_flicker_sample_bits));
`default_nettype wire

// [fifo_cfg_pkg.sv]
// Package: offsets, field positions and reset values of the FIFO write configuration
`default_nettype none
package fifo_cfg_pkg;
  localparam logic [7:0] MOD0_CFG_ADDR   = 8'hF9;
  localparam logic [7:0] MOD1_CFG_ADDR   = 8'hFA;
  localparam int         PUSH_EN_BIT     = 7;
  localparam int         RSVD_BIT        = 6;
  localparam int         COMPRESS_BIT    = 5;
  localparam int         DIFF_BIT        = 4;
  localparam int         WIDTH_MSB       = 3;
  localparam logic [7:0] CFG_RESET       = 8'h8F;
  localparam logic [7:0] CFG_WRITE_MASK  = 8'hBF;
  localparam int         SAMPLE_W        = 16;
  localparam int         COUNT_W         = 16;
endpackage : fifo_cfg_pkg
`default_nettype wire

// [fifo_sample_format_cfg.sv]
// FIFO write configuration registers and push gating for modulators 0 and 1
// Function
// - Per-modulator light push enable, bit 7, resets one
// - Push light only if flicker off or done, or final-after-flicker set
// - Early light needs final-processing-after-flicker set
// - Bit 5 enables flicker compression, resets zero
// - Bit 4 writes sample deltas, resets zero
// - Bits 3:0 keep sample bits 0..N
// - Bit 6 reserved, reads zero
`timescale 1ns/1ps
`default_nettype none
module fifo_sample_format_cfg
(
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                sys_rst,
  // Register port
  input  wire logic                                reg_wr,
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [7:0]                          reg_wdata,
  output logic [7:0]                               reg_rdata,
  output logic                                     reg_hit,
  // Sequencer state
  input  wire logic                                flicker_step_en,
  input  wire logic                                final_after_flicker,
  input  wire logic [fifo_cfg_pkg::COUNT_W-1:0]    light_sample_count,
  input  wire logic [fifo_cfg_pkg::COUNT_W-1:0]    flicker_sample_count,
  // Light results in
  input  wire logic [1:0]                          light_valid,
  input  wire logic [fifo_cfg_pkg::SAMPLE_W-1:0]   light_data0,
  input  wire logic [fifo_cfg_pkg::SAMPLE_W-1:0]   light_data1,
  // Flicker samples in
  input  wire logic [1:0]                          flicker_valid,
  input  wire logic [fifo_cfg_pkg::SAMPLE_W-1:0]   flicker_data0,
  input  wire logic [fifo_cfg_pkg::SAMPLE_W-1:0]   flicker_data1,
  // Light push out
  output logic [1:0]                               light_push,
  output logic [fifo_cfg_pkg::SAMPLE_W-1:0]        light_push_data0,
  output logic [fifo_cfg_pkg::SAMPLE_W-1:0]        light_push_data1,
  // Flicker push out
  output logic [1:0]                               flicker_push,
  output logic [1:0]                               flicker_compress,
  output logic [fifo_cfg_pkg::SAMPLE_W-1:0]        flicker_push_data0,
  output logic [fifo_cfg_pkg::SAMPLE_W-1:0]        flicker_push_data1,
  // Field views
  output logic                                     mod0_light_result_push_en,
  output logic                                     mod1_light_result_push_en,
  output logic [3:0]                               mod0_flicker_sample_bits,
  output logic [3:0]                               mod1_flicker_sample_bits
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] cfg [2];

  function automatic int addr_to_mod(input logic [7:0] a);
    if (a == fifo_cfg_pkg::MOD0_CFG_ADDR)
      return 0;
    else if (a == fifo_cfg_pkg::MOD1_CFG_ADDR)
      return 1;
    else
      return -1;
  endfunction : addr_to_mod

  // One register per modulator, written only on an exact address match
  genvar m;
  generate
    for (m = 0; m < 2; m++)
    begin : g_cfg
      logic [7:0] cfg_ff;
      logic [7:0] nxt_cfg;

      always_comb
      begin
        nxt_cfg = cfg_ff;
        if (reg_wr && addr_to_mod(reg_addr) == m)
          nxt_cfg = reg_wdata & fifo_cfg_pkg::CFG_WRITE_MASK;
      end

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          cfg_ff <= fifo_cfg_pkg::CFG_RESET;
        end
        else
        begin
          cfg_ff <= nxt_cfg;
        end
      end

      assign cfg[m] = cfg_ff;
    end
  endgenerate

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  // Read mux is combinational; a write shows one edge later
  always_comb
  begin
    reg_hit   = addr_to_mod(reg_addr) >= 0;
    reg_rdata = 8'h00;
    if (addr_to_mod(reg_addr) == 0)
      reg_rdata = cfg[0];
    else if (addr_to_mod(reg_addr) == 1)
      reg_rdata = cfg[1];
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  assign mod0_light_result_push_en = cfg[0][fifo_cfg_pkg::PUSH_EN_BIT];
  assign mod1_light_result_push_en = cfg[1][fifo_cfg_pkg::PUSH_EN_BIT];
  assign mod0_flicker_sample_bits  = cfg[0][fifo_cfg_pkg::WIDTH_MSB:0];
  assign mod1_flicker_sample_bits  = cfg[1][fifo_cfg_pkg::WIDTH_MSB:0];

  // ----------------------------------------
  // Light push gating
  // ----------------------------------------
  logic                              gate_open;
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] lin [2];
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] lpd [2];

  function automatic logic light_gate_open
  (
    input logic                             flicker_on,
    input logic                             final_after,
    input logic [fifo_cfg_pkg::COUNT_W-1:0] light_cnt,
    input logic [fifo_cfg_pkg::COUNT_W-1:0] flicker_cnt
  );
    if (!flicker_on)
      return 1'b1;
    else if (light_cnt >= flicker_cnt)
      return 1'b1;
    else
      return final_after;
  endfunction : light_gate_open

  assign lin[0] = light_data0;
  assign lin[1] = light_data1;

  assign gate_open = light_gate_open(flicker_step_en, final_after_flicker,
                                     light_sample_count, flicker_sample_count);

  generate
    for (m = 0; m < 2; m++)
    begin : g_light
      logic                              push_ff;
      logic                              nxt_push;
      logic [fifo_cfg_pkg::SAMPLE_W-1:0] lpd_ff;
      logic [fifo_cfg_pkg::SAMPLE_W-1:0] nxt_lpd;

      always_comb
      begin
        nxt_push = light_valid[m] && gate_open && cfg[m][fifo_cfg_pkg::PUSH_EN_BIT];
        // Data holds the last result, so a slow FIFO writer still sees it
        nxt_lpd  = light_valid[m] ? lin[m] : lpd_ff;
      end

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          push_ff <= 1'b0;
          lpd_ff  <= '0;
        end
        else
        begin
          push_ff <= nxt_push;
          lpd_ff  <= nxt_lpd;
        end
      end

      assign light_push[m] = push_ff;
      assign lpd[m]        = lpd_ff;
    end
  endgenerate

  assign light_push_data0 = lpd[0];
  assign light_push_data1 = lpd[1];

  // ----------------------------------------
  // Flicker sample shaping
  // ----------------------------------------
  // Delta without compression is still applied; keeping the pair legal is the host's duty
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] fin [2];
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] fout [2];
  assign fin[0] = flicker_data0;
  assign fin[1] = flicker_data1;

  generate
    for (m = 0; m < 2; m++)
    begin : g_shape
      flicker_sample_shaper u_shaper
      (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .diff_en      (cfg[m][fifo_cfg_pkg::DIFF_BIT]),
        .compress_en  (cfg[m][fifo_cfg_pkg::COMPRESS_BIT]),
        .sample_bits  (cfg[m][fifo_cfg_pkg::WIDTH_MSB:0]),
        .in_valid     (flicker_valid[m]),
        .in_sample    (fin[m]),
        .out_valid    (flicker_push[m]),
        .out_sample   (fout[m]),
        .out_compress (flicker_compress[m])
      );
    end
  endgenerate

  assign flicker_push_data0 = fout[0];
  assign flicker_push_data1 = fout[1];
endmodule : fifo_sample_format_cfg
`default_nettype wire

// [flicker_sample_shaper.sv]
// Flicker sample shaper: optional delta encoding and width truncation per modulator
`timescale 1ns/1ps
`default_nettype none
module flicker_sample_shaper
(
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                sys_rst,
  // Configuration
  input  wire logic                                diff_en,
  input  wire logic                                compress_en,
  input  wire logic [3:0]                          sample_bits,
  // Sample in
  input  wire logic                                in_valid,
  input  wire logic [fifo_cfg_pkg::SAMPLE_W-1:0]   in_sample,
  // Sample out
  output logic                                     out_valid,
  output logic [fifo_cfg_pkg::SAMPLE_W-1:0]        out_sample,
  output logic                                     out_compress
);
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] prev_ff;
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] nxt_prev;
  logic                              valid_ff;
  logic                              nxt_valid;
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] data_ff;
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] nxt_data;
  logic                              comp_ff;
  logic                              nxt_comp;
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] raw;
  logic [fifo_cfg_pkg::SAMPLE_W-1:0] keep_mask;

  always_comb
  begin
    nxt_prev  = prev_ff;
    nxt_valid = in_valid;
    nxt_data  = data_ff;
    nxt_comp  = comp_ff;
    raw = diff_en ? (in_sample - prev_ff) : in_sample;
    keep_mask = {fifo_cfg_pkg::SAMPLE_W{1'b1}} >> (4'hF - sample_bits);
    if (in_valid)
    begin
      nxt_prev = in_sample;
      nxt_data = raw & keep_mask;
      nxt_comp = compress_en;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_ff  <= '0;
      valid_ff <= 1'b0;
      data_ff  <= '0;
      comp_ff  <= 1'b0;
    end
    else
    begin
      prev_ff  <= nxt_prev;
      valid_ff <= nxt_valid;
      data_ff  <= nxt_data;
      comp_ff  <= nxt_comp;
    end
  end

  assign out_valid    = valid_ff;
  assign out_sample   = data_ff;
  assign out_compress = comp_ff;
endmodule : flicker_sample_shaper
`default_nettype wire

// [host_model.sv]
// Host model: register writes and reads on the register port
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock and read-back
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  // Register port
  output logic            reg_wr,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial {reg_wr, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    d[4] = d[4] & d[5];
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge mclk);
    // Released data is inverted so a stale value cannot match
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// [testbench.sv]
// Testbench: registers, light push gating and flicker sample shaping
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk = 0, sys_rst = 1, fse = 0, faf = 0, wr, hit, e0, e1;
  logic [1:0]  lv = 0, fv = 0, lp, fp, fcp;
  logic [7:0]  addr, wd, rd;
  logic [3:0]  b0, b1;
  logic [15:0] lc = 0, fc = 0, ld0 = 0, ld1 = 0, fd0 = 0, fd1 = 0, lpd0, lpd1, fpd0, fpd1;
  int          n_mismatch = 0, num_checks = 0;
  initial forever #5 mclk = ~mclk;
  host_model host_model_inst (.mclk(mclk), .reg_rdata(rd), .reg_wr(wr), .reg_addr(addr),
    .reg_wdata(wd));
  fifo_sample_format_cfg fifo_sample_format_cfg_inst (.mclk(mclk), .sys_rst(sys_rst),
    .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd), .reg_hit(hit),
    .flicker_step_en(fse), .final_after_flicker(faf), .light_sample_count(lc),
    .flicker_sample_count(fc), .light_valid(lv), .light_data0(ld0), .light_data1(ld1),
    .flicker_valid(fv), .flicker_data0(fd0), .flicker_data1(fd1), .light_push(lp),
    .light_push_data0(lpd0), .light_push_data1(lpd1), .flicker_push(fp),
    .flicker_compress(fcp), .flicker_push_data0(fpd0), .flicker_push_data1(fpd1),
    .mod0_light_result_push_en(e0), .mod1_light_result_push_en(e1),
    .mod0_flicker_sample_bits(b0), .mod1_flicker_sample_bits(b1));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic t_regs;
    logic [7:0] d;
    host_model_inst.rd(fifo_cfg_pkg::MOD1_CFG_ADDR, d);
    chk(d, 16'h008F);
    chk({e0, e1, b0, b1}, 16'h03FF);
    host_model_inst.wr(fifo_cfg_pkg::MOD0_CFG_ADDR, 8'hFF);
    host_model_inst.rd(fifo_cfg_pkg::MOD0_CFG_ADDR, d);
    chk(d, 16'h00BF);
    host_model_inst.wr(fifo_cfg_pkg::MOD1_CFG_ADDR, 8'h35);
    host_model_inst.rd(fifo_cfg_pkg::MOD1_CFG_ADDR, d);
    chk({hit, d}, 16'h0135);
    chk({e0, e1, b0, b1}, 16'h02F5);
    host_model_inst.rd(8'h10, d);
    chk({hit, d}, 16'h0000);
  endtask : t_regs
  // Case bits: flicker step, final control, light below flicker, push expected
  task automatic t_light;
    logic [3:0] tbl [4] = '{4'b0011, 4'b1001, 4'b1010, 4'b1111};
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      {fse, faf, lc, fc} = {tbl[i][3:2], tbl[i][1] ? 16'h0003 : 16'h0004, 16'h0004};
      {ld0, ld1, lv} = {16'h1000 + 16'(i), 16'h2000, 2'b11};
      @(negedge mclk);
      lv = 2'b00;
      chk(lp, {1'b0, tbl[i][0]});
      if (tbl[i][0])
        chk(lpd0, ld0);
      {ld0, ld1} = ~{ld0, ld1};
    end
  endtask : t_light
  task automatic fstep(input logic [15:0] s0, s1, x0, x1);
    @(negedge mclk);
    {fd0, fd1, fv} = {s0, s1, 2'b11};
    @(negedge mclk);
    {fd0, fd1, fv} = {~s0, ~s1, 2'b00};
    chk({fp, fcp}, 16'h000D);
    chk(fpd0, x0);
    chk(fpd1, x1);
  endtask : fstep
  task automatic t_flick;
    host_model_inst.wr(fifo_cfg_pkg::MOD0_CFG_ADDR, 8'hB7);
    host_model_inst.wr(fifo_cfg_pkg::MOD1_CFG_ADDR, 8'h0B);
    fstep(16'h1234, 16'hABCD, 16'h0034, 16'h0BCD);
    fstep(16'h1300, 16'h0FFF, 16'h00CC, 16'h0FFF);
  endtask : t_flick
  task automatic t_light1;
    host_model_inst.wr(fifo_cfg_pkg::MOD1_CFG_ADDR, 8'h8F);
    @(negedge mclk);
    {fse, ld1, lv} = {1'b0, 16'h5A5A, 2'b10};
    @(negedge mclk);
    lv = 2'b00;
    chk(lp, 16'h0002);
    chk(lpd1, 16'h5A5A);
    chk(lpd0, 16'h1003);
  endtask : t_light1
  task automatic t_reset;
    logic [7:0] d;
    @(negedge mclk);
    sys_rst = 1;
    repeat (2) @(negedge mclk);
    sys_rst = 0;
    chk({lp, fp, fcp}, 16'h0000);
    chk(lpd0 | lpd1 | fpd0 | fpd1, 16'h0000);
    chk({e0, e1, b0, b1}, 16'h03FF);
    host_model_inst.rd(fifo_cfg_pkg::MOD0_CFG_ADDR, d);
    chk(d, 16'h008F);
    host_model_inst.wr(fifo_cfg_pkg::MOD0_CFG_ADDR, 8'hBF);
    fstep(16'h0050, 16'h0123, 16'h0050, 16'h0123);
  endtask : t_reset
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (10) @(negedge mclk);
    sys_rst = 0;
    t_regs;
    t_light;
    t_light1;
    t_flick;
    t_reset;
    final_report;
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #20000;
    n_mismatch++;
    final_report;
  end
endmodule : testbench
`default_nettype wire
